// ==== acs_device.sv ====
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "acs_defines.svh"
// Operation
// - Deselected: ignore clock and data, release output
// - Ready output is always driven
// - Shared data line works for register access
// - Reset pin or 32 ones resets
// - Host avoids stray clocks, resets first
// - Command byte precedes every register transfer
// - Host sends zeros while reading
// - Mode write clears flags, ready high
// - Single conversion updates, idles, flags, ready low
// - Data read clears flag, ready high
// - Dump mode prepends channel status
// - Host keeps data low during dump read
// - Continuous mode cycles enabled channels
// - Scan period sums enabled conversion times
// - Ready pin any or all enabled, all only in continuous mode
// - Overwrite drops flag, ready high 163 cycles
// - Result for the channel whose data is being read out is discarded
// - Single conversion ignores channel enable
module acs_device #(
   parameter logic [7:0] OVR_HOLD = `ACS_OVR_HOLD
) (
   input  wire logic        CLK,
   input  wire logic        RSTN,
   acs_if.dev               LINK,
   input  wire logic [23:0] SAMPLE,
   output logic             CONV_BUSY
);
   function automatic logic [5:0] xfer_len(input logic [3:0] g, input logic dmp);
      logic chan;
      chan = (g == `ACS_GRP_CHSTAT) || (g == `ACS_GRP_DATA);
      if (chan && dmp)
         xfer_len = `ACS_LEN_DUMP;
      else if (g == `ACS_GRP_DATA)
         xfer_len = `ACS_LEN_DATA;
      else
         xfer_len = `ACS_LEN_REG;
   endfunction

   function automatic logic [1:0] next_chan(input logic [1:0] c, input logic [3:0] en);
      logic [1:0] n;
      integer     i;
      next_chan = c;
      for (i = 3; i >= 1; i--) begin
         n = c + 2'(i);
         if (en[n])
            next_chan = n;
      end
   endfunction

   logic [2:0] cs_s, ck_s, di_s, rp_s;
   logic       cs_f, ck_f, di_f, rp_f;
   wire        cs_new = (cs_s[1] == cs_s[2]) ? cs_s[2] : cs_f;
   wire        ck_new = (ck_s[1] == ck_s[2]) ? ck_s[2] : ck_f;
   wire        di_new = (di_s[1] == di_s[2]) ? di_s[2] : di_f;
   wire        rp_new = (rp_s[1] == rp_s[2]) ? rp_s[2] : rp_f;

   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         cs_s <= 3'h7;
         ck_s <= 3'h7;
         di_s <= 3'h0;
         rp_s <= 3'h7;
         cs_f <= 1'b1;
         ck_f <= 1'b1;
         di_f <= 1'b0;
         rp_f <= 1'b1;
      end else begin
         cs_s <= {cs_s[1:0], LINK.cs_n};
         ck_s <= {ck_s[1:0], LINK.sclk};
         di_s <= {di_s[1:0], LINK.din};
         rp_s <= {rp_s[1:0], LINK.reset_n};
         cs_f <= cs_new;
         ck_f <= ck_new;
         di_f <= di_new;
         rp_f <= rp_new;
      end
   end

   wire rise = ck_new & ~ck_f & ~cs_f;
   wire fall = ~ck_new & ck_f & ~cs_f;

   logic [5:0] ones;
   wire ser_rst = rise && di_new && (ones == `ACS_RST_ONES - 6'h01);
   wire srst    = !RSTN || !rp_f || ser_rst;

   always_ff @(posedge CLK) begin
      if (srst)
         ones <= 6'h00;
      else if (rise)
         ones <= di_new ? ones + 6'h01 : 6'h00;
   end

   logic                phase;
   logic                rd;
   logic                first;
   logic [5:0]          cnt;
   logic [5:0]          len;
   logic [7:0]          cmd;
   logic [31:0]         sh_in;
   logic [31:0]         sh_out;
   acs_pkg::acs_mode_type mode;
   logic                dump;
   logic                ready_pin_function_sel;
   logic [1:0]          conv_ch;
   logic [15:0]         conv_cnt;
   logic [3:0]          flags;
   logic [7:0]          hold_cnt;
   logic [1:0]          hold_ch;
   logic                rdy_n;
   logic                busy;
   logic [23:0]         data   [4];
   logic [7:0]          chstat [4];
   logic [7:0]          setup  [4];
   logic [7:0]          ctime  [4];
   logic [3:0]          en;

   always_comb begin
      en = 4'h0;
      for (int k = 0; k < 4; k++)
         en[k] = setup[k][`ACS_SETUP_EN];
   end

   wire [3:0]  grp     = cmd[5:2];
   wire [1:0]  ch      = cmd[1:0];
   wire [7:0]  nxt_cmd = {sh_in[6:0], di_new};
   wire        cmd_end = rise && !phase && (cnt == `ACS_LEN_CMD - 6'h01);
   wire        xfr_end = rise && phase && (cnt == len - 6'h01);
   wire        wr_end  = xfr_end && !rd;
   wire        mode_wr = wr_end && (grp == `ACS_GRP_MODE);
   wire        dump_rd = dump && ((grp == `ACS_GRP_CHSTAT) || (grp == `ACS_GRP_DATA));
   wire        data_rd = phase && rd && (dump_rd || grp == `ACS_GRP_DATA);
   wire        load    = fall && phase && rd && first;

   wire [3:0]  hold_m  = (hold_cnt != 8'h00) ? (4'h1 << hold_ch) : 4'h0;
   wire [3:0]  vis     = flags & ~hold_m;
   wire [7:0]  cst     = {chstat[ch][7:1], vis[ch]};
   wire [7:0]  rd_byte = (grp == `ACS_GRP_CTRL)  ? ((ch == 2'h0) ? {4'h0, vis} : {7'h0, ready_pin_function_sel}) :
                         (grp == `ACS_GRP_CHSTAT) ? cst :
                         (grp == `ACS_GRP_SETUP)  ? setup[ch] :
                         (grp == `ACS_GRP_CTIME)  ? ctime[ch] :
                         (grp == `ACS_GRP_MODE)   ? {mode, 1'b0, dump, 3'h0} : 8'h00;
   wire [31:0] rd_word = dump_rd ? {cst, data[ch]} :
                         (grp == `ACS_GRP_DATA) ? {data[ch], 8'h00} : {rd_byte, 24'h0};

   always_ff @(posedge CLK) begin
      if (srst) begin
         phase <= 1'b0;
         cnt   <= 6'h00;
         rd    <= 1'b0;
         first <= 1'b0;
         len   <= `ACS_LEN_REG;
         cmd   <= 8'h00;
         sh_in <= 32'h0;
      end else if (rise) begin
         sh_in <= {sh_in[30:0], di_new};
         cnt   <= (cmd_end || xfr_end) ? 6'h00 : cnt + 6'h01;
         if (cmd_end) begin
            cmd   <= nxt_cmd;
            rd    <= nxt_cmd[`ACS_CMD_RD_BIT];
            len   <= xfer_len(nxt_cmd[5:2], dump);
            phase <= 1'b1;
            first <= 1'b1;
         end else if (xfr_end) begin
            phase <= 1'b0;
         end
      end else if (load) begin
         first <= 1'b0;
      end
   end

   // Load on the first falling edge so the MSB is valid for the first rising edge
   always_ff @(posedge CLK) begin
      if (srst)
         sh_out <= 32'h0;
      else if (load)
         sh_out <= rd_word;
      else if (fall && phase && rd)
         sh_out <= {sh_out[30:0], 1'b0};
   end

   // Output released outside reads, so a shared data line needs no extra logic
   assign LINK.dout_o    = sh_out[31];
   assign LINK.dout_oe_n = !(!cs_f && phase && rd && !first);

   wire [7:0]  io_rst  = `ACS_IO_RST;

   always_ff @(posedge CLK) begin
      if (srst) begin
         ready_pin_function_sel <= io_rst[`ACS_READY_PIN_FUNCTION_SEL_BIT];
         for (int k = 0; k < 4; k++) begin
            setup[k] <= `ACS_SETUP_RST;
            ctime[k] <= `ACS_CTIME_RST;
         end
      end else if (wr_end) begin
         if (grp == `ACS_GRP_CTRL && ch == 2'h1)
            ready_pin_function_sel <= nxt_cmd[`ACS_READY_PIN_FUNCTION_SEL_BIT];
         if (grp == `ACS_GRP_SETUP)
            setup[ch] <= nxt_cmd;
         if (grp == `ACS_GRP_CTIME)
            ctime[ch] <= nxt_cmd;
      end
   end

   wire        conv_on  = (mode == acs_pkg::M_CONT) || (mode == acs_pkg::M_SINGLE);
   // Period per channel scales with its own time register; a scan sums them
   wire [15:0] conv_tgt = (16'(ctime[conv_ch]) + 16'h0001) << `ACS_CONV_SHIFT;
   wire        conv_end = conv_on && (conv_cnt == conv_tgt - 16'h0001);
   wire        clash    = conv_end && data_rd && (ch == conv_ch);
   wire        land     = conv_end && !clash;
   wire [3:0]  set_m    = land ? (4'h1 << conv_ch) : 4'h0;
   wire [3:0]  clr_m    = (load && data_rd) ? (4'h1 << ch) : 4'h0;

   always_ff @(posedge CLK) begin
      if (srst) begin
         mode     <= acs_pkg::M_IDLE;
         dump     <= 1'b0;
         conv_ch  <= 2'h0;
         conv_cnt <= 16'h0000;
      end else if (mode_wr) begin
         mode     <= acs_pkg::acs_mode_type'(nxt_cmd[`ACS_MODE_MSB:`ACS_MODE_LSB]);
         dump     <= nxt_cmd[`ACS_DUMP_BIT];
         conv_ch  <= ch;
         conv_cnt <= 16'h0000;
      end else if (conv_end) begin
         conv_cnt <= 16'h0000;
         if (mode == acs_pkg::M_SINGLE)
            mode <= acs_pkg::M_IDLE;
         else
            conv_ch <= next_chan(conv_ch, en);
      end else if (conv_on) begin
         conv_cnt <= conv_cnt + 16'h0001;
      end
   end

   always_ff @(posedge CLK) begin
      if (srst) begin
         for (int k = 0; k < 4; k++) begin
            data[k]   <= 24'h0;
            chstat[k] <= 8'h00;
         end
      end else if (land) begin
         data[conv_ch]   <= SAMPLE;
         chstat[conv_ch] <= {conv_ch, 4'h0, SAMPLE[23], 1'b0};
      end
   end

   // Set wins over a same-cycle read clear
   always_ff @(posedge CLK) begin
      if (srst || mode_wr)
         flags <= 4'h0;
      else
         flags <= (flags & ~clr_m) | set_m;
   end

   always_ff @(posedge CLK) begin
      if (srst || mode_wr) begin
         hold_cnt <= 8'h00;
         hold_ch  <= 2'h0;
      end else if (land && flags[conv_ch]) begin
         hold_cnt <= OVR_HOLD;
         hold_ch  <= conv_ch;
      end else if (hold_cnt != 8'h00) begin
         hold_cnt <= hold_cnt - 8'h01;
      end
   end

   wire all_rdy   = (en != 4'h0) && ((vis & en) == en);
   wire next_rdy_n = mode_wr ? 1'b1 :
                    (hold_cnt != 8'h00 || (land && flags[conv_ch])) ? 1'b1 :
                    (mode == acs_pkg::M_CONT && ready_pin_function_sel) ? !all_rdy : !(|vis);

   always_ff @(posedge CLK) begin
      if (srst) begin
         rdy_n <= 1'b1;
         busy  <= 1'b0;
      end else begin
         rdy_n <= next_rdy_n;
         busy  <= conv_on;
      end
   end

   assign LINK.rdy_n = rdy_n;
   assign CONV_BUSY  = busy;
endmodule
`default_nettype wire

// ==== acs_defines.svh ====
`ifndef ACS_DEFINES_SVH
`define ACS_DEFINES_SVH
// Device side register groups, address bits [5:2] of the command byte
`define ACS_GRP_CTRL    4'h0
`define ACS_GRP_CHSTAT  4'h1
`define ACS_GRP_DATA    4'h2
`define ACS_GRP_SETUP   4'hA
`define ACS_GRP_CTIME   4'hC
`define ACS_GRP_MODE    4'hE
`define ACS_CMD_RD_BIT  6
`define ACS_MODE_MSB    7
`define ACS_MODE_LSB    5
`define ACS_DUMP_BIT    3
`define ACS_SETUP_EN    3
`define ACS_READY_PIN_FUNCTION_SEL_BIT   0
`define ACS_LEN_CMD     6'h08
`define ACS_LEN_REG     6'h08
`define ACS_LEN_DATA    6'h18
`define ACS_LEN_DUMP    6'h20
`define ACS_RST_ONES    6'h20
`define ACS_OVR_HOLD    8'hA3
`define ACS_CONV_SHIFT  4
`define ACS_SETUP_RST   8'h00
`define ACS_CTIME_RST   8'h00
`define ACS_IO_RST      8'h00
// Host side register map
`define ACS_H_CTRL      4'h0
`define ACS_H_TX        4'h1
`define ACS_H_RX        4'h2
`define ACS_H_STAT      4'h3
`define ACS_H_IST       4'h4
`define ACS_H_IMASK     4'h5
`define ACS_H_PRST      4'h6
`define ACS_H_START     8
`define ACS_H_HALF      10
`endif

// ==== acs_pkg.sv ====
package acs_pkg;
   typedef enum logic [2:0] {
      M_IDLE   = 3'b000,
      M_CONT   = 3'b001,
      M_SINGLE = 3'b010
   } acs_mode_type;
   typedef enum logic [1:0] {
      H_IDLE = 2'b00,
      H_LEAD = 2'b01,
      H_LOW  = 2'b10,
      H_HIGH = 2'b11
   } acs_hstate_type;
endpackage

// ==== acs_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface acs_if;
   logic cs_n;
   logic sclk;
   logic din;
   logic reset_n;
   logic dout_o;
   logic dout_oe_n;
   logic rdy_n;
   // Released line idles high, as with a pull-up
   wire  dout = dout_oe_n ? 1'b1 : dout_o;
   modport dev (input cs_n, sclk, din, reset_n, output dout_o, dout_oe_n, rdy_n);
   modport host (output cs_n, sclk, din, reset_n, input dout, rdy_n);
endinterface
`default_nettype wire

// ==== acs_host.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "acs_defines.svh"
module acs_host #(
   parameter int HALF = `ACS_H_HALF
) (
   input  wire logic        CLK,
   input  wire logic        RSTN,
   input  wire logic [3:0]  ADDR,
   input  wire logic [31:0] WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output logic [31:0]      RDATA,
   output logic             IRQ,
   acs_if.host              LINK
);
   logic [2:0]             ds, rs;
   logic                   d_f, r_f;
   wire                    d_new = (ds[1] == ds[2]) ? ds[2] : d_f;
   wire                    r_new = (rs[1] == rs[2]) ? rs[2] : r_f;
   acs_pkg::acs_hstate_type st;
   logic [7:0]             div;
   logic [5:0]             left;
   logic [31:0]            tx, rx, rdata;
   logic [1:0]             ist, imask;
   logic                   prst, cs_n, sclk, din;

   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         ds  <= 3'h7;
         rs  <= 3'h7;
         d_f <= 1'b1;
         r_f <= 1'b1;
      end else begin
         ds  <= {ds[1:0], LINK.dout};
         rs  <= {rs[1:0], LINK.rdy_n};
         d_f <= d_new;
         r_f <= r_new;
      end
   end

   wire tick  = div == 8'(HALF - 1);
   wire idle  = st == acs_pkg::H_IDLE;
   wire go    = WR && ADDR == `ACS_H_CTRL && WDATA[`ACS_H_START] && idle && WDATA[5:0] != 6'h00;
   wire done  = st == acs_pkg::H_HIGH && tick && left == 6'h00;
   wire fallr = r_f && !r_new;
   wire [1:0] ev  = {fallr, done};
   wire [1:0] w1c = (WR && ADDR == `ACS_H_IST) ? WDATA[1:0] : 2'h0;

   always_ff @(posedge CLK) begin
      if (!RSTN || idle || tick)
         div <= 8'h00;
      else
         div <= div + 8'h01;
   end

   // Clock toggles only with select low; tail of the word is zero fill
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         st   <= acs_pkg::H_IDLE;
         cs_n <= 1'b1;
         sclk <= 1'b1;
         din  <= 1'b0;
         left <= 6'h00;
         tx   <= 32'h0;
         rx   <= 32'h0;
      end else begin
         unique case (st)
            acs_pkg::H_IDLE: begin
               if (WR && ADDR == `ACS_H_TX)
                  tx <= WDATA;
               if (go) begin
                  cs_n <= 1'b0;
                  din  <= tx[31];
                  left <= WDATA[5:0];
                  st   <= acs_pkg::H_LEAD;
               end
            end
            acs_pkg::H_LEAD: begin
               if (tick) begin
                  sclk <= 1'b0;
                  st   <= acs_pkg::H_LOW;
               end
            end
            acs_pkg::H_LOW: begin
               if (tick) begin
                  sclk <= 1'b1;
                  rx   <= {rx[30:0], d_f};
                  left <= left - 6'h01;
                  st   <= acs_pkg::H_HIGH;
               end
            end
            acs_pkg::H_HIGH: begin
               if (tick && left == 6'h00) begin
                  cs_n <= 1'b1;
                  st   <= acs_pkg::H_IDLE;
               end else if (tick) begin
                  sclk <= 1'b0;
                  din  <= tx[30];
                  tx   <= {tx[30:0], 1'b0};
                  st   <= acs_pkg::H_LOW;
               end
            end
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         ist   <= 2'h0;
         imask <= 2'h0;
         prst  <= 1'b0;
      end else begin
         ist <= (ist & ~w1c) | ev;
         if (WR && ADDR == `ACS_H_IMASK)
            imask <= WDATA[1:0];
         if (WR && ADDR == `ACS_H_PRST)
            prst <= WDATA[0];
      end
   end

   wire [31:0] rd_mux = (ADDR == `ACS_H_CTRL)  ? {26'h0, left} :
                        (ADDR == `ACS_H_TX)    ? tx :
                        (ADDR == `ACS_H_RX)    ? rx :
                        (ADDR == `ACS_H_STAT)  ? {30'h0, r_f, !idle} :
                        (ADDR == `ACS_H_IST)   ? {30'h0, ist} :
                        (ADDR == `ACS_H_IMASK) ? {30'h0, imask} :
                        (ADDR == `ACS_H_PRST)  ? {31'h0, prst} : 32'h0;

   always_ff @(posedge CLK) begin
      if (!RSTN || !RD)
         rdata <= 32'h0;
      else
         rdata <= rd_mux;
   end

   assign RDATA        = rdata;
   assign IRQ          = |(ist & imask);
   assign LINK.cs_n    = cs_n;
   assign LINK.sclk    = sclk;
   assign LINK.din     = din;
   assign LINK.reset_n = !prst;
endmodule
`default_nettype wire

// ==== acs_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module acs_chk (
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic din,
   input wire logic reset_n,
   input wire logic dout_o,
   input wire logic dout_oe_n,
   input wire logic rdy_n
);
   logic        sclk_d;
   logic        mode_wr;
   logic [5:0]  bits;
   logic [5:0]  ones;
   logic [14:0] shreg;
   // Raw edges; the device sees them a few cycles later
   wire rise = sclk && !sclk_d && !cs_n;
   wire next_mode_wr = rise && bits == 6'h0F && !shreg[13] && shreg[12:9] == 4'hE;
   always_ff @(posedge CLK) begin
      sclk_d <= sclk;
      mode_wr <= next_mode_wr;
      if (!RSTN || cs_n) begin
         bits <= 6'h00;
         ones <= 6'h00;
      end else if (rise) begin
         bits <= bits + 6'h01;
         shreg <= {shreg[13:0], din};
         ones <= din ? ones + {5'h00, ones != 6'h20} : 6'h00;
      end
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (!RSTN);
   a_release_idle: assert property (cs_n [*6] |-> dout_oe_n)
      else $error("data line driven while deselected");
   a_drive_selected: assert property ($fell(dout_oe_n) |-> !cs_n && !sclk)
      else $error("drive began outside a falling clock");
   // Every length is whole bytes, so each command ends on a byte boundary of the frame
   a_drive_read: assert property ($fell(dout_oe_n) |->
      bits[2:0] == 3'h0 && bits != 6'h00 && shreg[6])
      else $error("drive began without a read command");
   a_cmd_first: assert property (!cs_n && bits < 6'h08 |-> dout_oe_n)
      else $error("drive during command byte");
   a_bit_stable: assert property (!dout_oe_n && !cs_n && sclk && $past(sclk) |-> $stable(dout_o))
      else $error("data bit moved while clock high");
   a_reset_pin: assert property (!reset_n [*6] |-> rdy_n && dout_oe_n)
      else $error("reset pin ignored");
   a_serial_reset: assert property (ones == 6'h20 |-> ##[1:8] rdy_n)
      else $error("ones sequence ignored");
   a_mode_clears: assert property (mode_wr |-> ##[1:8] rdy_n)
      else $error("mode write left ready low");
   c_ready: cover property ($fell(rdy_n));
   c_mode: cover property (mode_wr);
   c_ones: cover property (ones == 6'h20);
   c_drive: cover property ($fell(dout_oe_n));
endmodule
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic [3:0]  addr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [23:0] sample = 24'h0;
   logic [31:0] rdata;
   logic [31:0] rx;
   logic        irq;
   logic        conv_busy;
   int          bad_count = 0;
   int          comparisons = 0;
   time         t0;
   acs_if link ();
   acs_device i_acs_device (.CLK(clk), .RSTN(rstn), .LINK(link), .SAMPLE(sample),
      .CONV_BUSY(conv_busy));
   acs_host i_acs_host (.CLK(clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr),
      .RD(rd), .RDATA(rdata), .IRQ(irq), .LINK(link));
   acs_chk i_acs_chk (.CLK(clk), .RSTN(rstn), .cs_n(link.cs_n), .sclk(link.sclk),
      .din(link.din), .reset_n(link.reset_n), .dout_o(link.dout_o),
      .dout_oe_n(link.dout_oe_n), .rdy_n(link.rdy_n));
   always #10 clk = ~clk;
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask
   task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   // Polls the status register; each poll costs two cycles
   task automatic wait_rdy(input logic v);
      logic [31:0] s;
      int n;
      n = 0;
      do begin
         bus_rd(4'h3, s);
         n++;
      end while (s[1] !== v && n < 9000);
      check(32'(s[1]), 32'(v), "ready level");
   endtask
   task automatic xfer(input logic [5:0] n, input logic [31:0] tx);
      logic [31:0] s;
      int k;
      k = 0;
      bus_wr(4'h1, tx);
      bus_wr(4'h0, {23'h0, 1'b1, 2'h0, n});
      do begin
         bus_rd(4'h4, s);
         k++;
      end while (s[0] !== 1'b1 && k < 1000);
      check(32'(s[0]), 32'h1, "transfer done");
      bus_wr(4'h4, 32'h1);
      bus_rd(4'h2, rx);
   endtask
   task automatic dev_wr(input logic [7:0] cmd, input logic [7:0] val);
      xfer(6'h10, {cmd, val, 16'h0});
   endtask
   task automatic dev_rd(input logic [7:0] cmd, input logic [5:0] n);
      xfer(n, {cmd, 24'h0});
   endtask
   initial begin
      repeat (40000) @(posedge clk);
      bad_count++;
      tally_and_finish();
   end
   initial begin
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      repeat (4) @(posedge clk);
      bus_rd(4'h3, rx);
      check(32'(rx[1:0]), 32'h2, "idle status");
      xfer(6'h20, 32'hFFFFFFFF);
      dev_wr(8'h01, 8'h01);
      dev_rd(8'h41, 6'h10);
      check(32'(rx[7:0]), 32'h1, "io readback");
      xfer(6'h20, 32'hFFFFFFFF);
      dev_rd(8'h41, 6'h10);
      check(32'(rx[7:0]), 32'h0, "serial reset");
      // Single conversion on a disabled channel
      bus_wr(4'h4, 32'h3);
      bus_wr(4'h5, 32'h2);
      sample <= 24'hA5C317;
      dev_wr(8'h3A, 8'h40);
      wait_rdy(1'b0);
      check(32'(irq), 32'h1, "irq raised");
      bus_wr(4'h4, 32'h2);
      #1;
      check(32'(irq), 32'h0, "irq cleared");
      bus_wr(4'h5, 32'h0);
      dev_rd(8'h7A, 6'h10);
      check(32'(rx[7:5]), 32'h0, "mode idle");
      check(32'(conv_busy), 32'h0, "busy off");
      dev_rd(8'h4A, 6'h20);
      check(32'(rx[23:0]), 32'hA5C317, "single data");
      bus_rd(4'h3, rx);
      check(32'(rx[1]), 32'h1, "read clears");
      sample <= 24'h3C5A96;
      dev_wr(8'h3A, 8'h48);
      wait_rdy(1'b0);
      dev_rd(8'h46, 6'h28);
      check(32'(rx[23:0]), 32'h3C5A96, "dump data");
      check(32'(rx[31:30]), 32'h2, "dump channel");
      dev_wr(8'h3A, 8'h40);
      wait_rdy(1'b0);
      dev_wr(8'h38, 8'h00);
      bus_rd(4'h3, rx);
      check(32'(rx[1]), 32'h1, "mode write");
      // Continuous scan, two channels of 4096 cycles each
      dev_wr(8'h28, 8'h08);
      dev_wr(8'h29, 8'h08);
      dev_wr(8'h30, 8'hFF);
      dev_wr(8'h31, 8'hFF);
      dev_wr(8'h01, 8'h01);
      sample <= 24'h5A0F3C;
      dev_wr(8'h38, 8'h20);
      t0 = $time;
      check(32'(conv_busy), 32'h1, "scan running");
      repeat (5000) @(posedge clk);
      bus_rd(4'h3, rx);
      check(32'(rx[1]), 32'h1, "one of two");
      wait_rdy(1'b0);
      check(32'(($time - t0) / 20 > 8100 && ($time - t0) / 20 < 8260), 32'h1, "scan");
      wait_rdy(1'b1);
      t0 = $time;
      wait_rdy(1'b0);
      check(32'(($time - t0) / 20 > 160 && ($time - t0) / 20 < 180), 32'h1, "overwrite");
      dev_rd(8'h49, 6'h20);
      check(32'(rx[23:0]), 32'h5A0F3C, "scan data");
      bus_rd(4'h3, rx);
      check(32'(rx[1]), 32'h1, "all needed");
      dev_wr(8'h01, 8'h00);
      bus_rd(4'h3, rx);
      check(32'(rx[1]), 32'h0, "any suffices");
      bus_wr(4'h6, 32'h1);
      repeat (10) @(posedge clk);
      bus_wr(4'h6, 32'h0);
      repeat (10) @(posedge clk);
      #1;
      check(32'(conv_busy), 32'h0, "pin reset");
      bus_rd(4'h3, rx);
      check(32'(rx[1]), 32'h1, "pin reset ready");
      // Short conversion so the second one ends inside the data readout
      dev_wr(8'h30, 8'h0F);
      sample <= 24'h0F1E2D;
      dev_wr(8'h38, 8'h40);
      wait_rdy(1'b0);
      dev_rd(8'h48, 6'h20);
      check(32'(rx[23:0]), 32'h0F1E2D, "short single");
      sample <= 24'h778899;
      dev_wr(8'h38, 8'h40);
      dev_rd(8'h48, 6'h20);
      bus_rd(4'h3, rx);
      check(32'(rx[1]), 32'h1, "clash no flag");
      dev_rd(8'h48, 6'h20);
      check(32'(rx[23:0]), 32'h0F1E2D, "clash kept");
      tally_and_finish();
   end
endmodule
`default_nettype wire
